// *** src/temp_sched_pkg.sv ***
/*
 * Constants and types shared by the temperature conversion scheduler:
 * register pointers, write masks, reset values, bit positions, timing.
 * Assumes a 200 MHz core clock and a host on the two-wire serial port.
 */
package temp_sched_pkg;

	// ==========================================================
	// Register pointers
	localparam logic [7:0] PTR_STATUS = 8'h08;
	localparam logic [7:0] PTR_RUN_CFG = 8'h09;
	localparam logic [7:0] PTR_CHANNEL_SETUP = 8'h0a;
	localparam logic [7:0] PTR_RATE = 8'h0b;
	localparam logic [7:0] PTR_ONE_SHOT = 8'h0f;

	// ==========================================================
	// Reset values and writable bits
	localparam logic [7:0] RATE_RESET = 8'h07;
	localparam logic [7:0] RUN_CFG_RESET = 8'h00;
	localparam logic [7:0] CHANNEL_SETUP_RESET = 8'h3c;
	localparam logic [7:0] RUN_CFG_WR_MASK = 8'h44;
	localparam logic [7:0] CHANNEL_SETUP_WR_MASK = 8'h7c;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ==========================================================
	// Field positions
	localparam int HALT_BIT = 6;
	localparam int RANGE_BIT = 2;
	localparam int FIX_EN_BIT = 2;
	localparam int LOCAL_EN_BIT = 3;
	localparam int BUSY_BIT = 7;
	localparam int RATE_CODE_W = 3;
	localparam int NUM_CHAN = 4;

	// ==========================================================
	// Serial target address
	localparam logic [6:0] TARGET_ADDR = 7'h4c;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ==========================================================
	// Timing: one tick is 1/8 s, code 0 spans 128 ticks (16 s)
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS = 125_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int CONV_TIME_NS = 20_000_000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SLOWEST_TICKS = 8'h80;
	localparam logic [7:0] ELAPSED_MAX = 8'hff;

	// ==========================================================
	// State types
	typedef enum logic [2:0] {
		BUS_IDLE, BUS_RX, BUS_ACK_SETUP, BUS_ACK, BUS_TX, BUS_TX_ACK
	} bus_state_type;

	typedef enum logic [1:0] {KIND_ADDR, KIND_PTR, KIND_DATA} byte_kind_type;

	typedef enum logic [1:0] {SEQ_CONV, SEQ_IDLE, SEQ_HALT} seq_state_type;

endpackage : temp_sched_pkg

// *** src/sched_link_if.sv ***
/*
 * Link between the register side and the sequence engine.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface sched_link_if;
	logic [2:0] rate_code;
	logic [3:0] chan_en;
	logic halt;
	logic one_shot;
	logic busy;
	logic [1:0] active_chan;

	modport regs (output rate_code, output chan_en, output halt, output one_shot,
		input busy, input active_chan);
	modport engine (input rate_code, input chan_en, input halt, input one_shot,
		output busy, output active_chan);
endinterface : sched_link_if

// *** src/sequence_engine.sv ***
/*
 * Measurement sequence engine: walks enabled channels, then waits out
 * the rate interval, or stops when halted.
 * Assumes a synchronous, already released reset and one clock.
 */
`timescale 1ns/1ps
module sequence_engine #(
	parameter int TICK_CYCLES = temp_sched_pkg::TICK_CYCLES,
	parameter int CONV_CYCLES = temp_sched_pkg::CONV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_sync_b,
	sched_link_if.engine link
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int CONV_W = $clog2(CONV_CYCLES + 1);

	temp_sched_pkg::seq_state_type state_q, state_d;
	logic [1:0] chan_q, chan_d;
	logic [TICK_W-1:0] tick_q, tick_d;
	logic [CONV_W-1:0] conv_q, conv_d;
	logic [7:0] elapsed_q, elapsed_d;
	logic [7:0] used_q, used_d;
	logic [7:0] wait_ticks;
	logic [7:0] nominal_ticks;
	logic [2:0] first_ch;
	logic [2:0] next_ch;

	// ==========================================================
	// Helpers
	// Lowest enabled channel at or above start, with a valid flag on top
	function automatic logic [2:0] first_from(input logic [3:0] en, input logic [2:0] start);
		logic [2:0] r;
		r = 3'h0;
		for (int i = temp_sched_pkg::NUM_CHAN - 1; i >= 0; i--) begin
			if (en[i] && (i >= int'(start))) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction : first_from

	function automatic logic [7:0] count_en(input logic [3:0] en);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < temp_sched_pkg::NUM_CHAN; i++) begin
			c = c + {7'h00, en[i]};
		end
		return c;
	endfunction : count_en

	// Period is the nominal code period, but never below one tick per used
	// channel: that caps the fast codes by channel count
	assign nominal_ticks = temp_sched_pkg::SLOWEST_TICKS >> link.rate_code;
	assign wait_ticks = (nominal_ticks > used_q) ? nominal_ticks : used_q;
	assign first_ch = first_from(link.chan_en, 3'h0);
	assign next_ch = first_from(link.chan_en, {1'b0, chan_q} + 3'h1);

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_d = state_q;
		chan_d = chan_q;
		conv_d = conv_q;
		used_d = used_q;
		tick_d = tick_q + TICK_W'(1);
		elapsed_d = elapsed_q;
		// Tick time runs across conversions and idle alike
		if (tick_q == TICK_W'(TICK_CYCLES - 1)) begin
			tick_d = '0;
			if (elapsed_q != temp_sched_pkg::ELAPSED_MAX) begin
				elapsed_d = elapsed_q + 8'h01;
			end
		end
		unique case (state_q)
			temp_sched_pkg::SEQ_CONV: begin
				// Fixed conversion length, whatever the rate code
				if (conv_q == CONV_W'(CONV_CYCLES - 1)) begin
					conv_d = '0;
					if (next_ch[2]) begin
						chan_d = next_ch[1:0];
					end else if (link.halt) begin
						state_d = temp_sched_pkg::SEQ_HALT;
					end else begin
						state_d = temp_sched_pkg::SEQ_IDLE;
					end
				end else begin
					conv_d = conv_q + CONV_W'(1);
				end
			end
			temp_sched_pkg::SEQ_IDLE: begin
				if (link.halt && !link.one_shot) begin
					state_d = temp_sched_pkg::SEQ_HALT;
				end
			end
			temp_sched_pkg::SEQ_HALT: begin
				state_d = temp_sched_pkg::SEQ_HALT;
			end
		endcase
		// Sequence start: one-shot out of idle or halt, rate expiry, or resume
		if ((state_q != temp_sched_pkg::SEQ_CONV) && (link.one_shot
			|| (state_q == temp_sched_pkg::SEQ_IDLE && !link.halt
			&& elapsed_q >= wait_ticks)
			|| (state_q == temp_sched_pkg::SEQ_HALT && !link.halt))) begin
			// The start edge is the first cycle of the new period, so the
			// period is exactly a whole number of ticks, not one cycle over
			tick_d = TICK_W'(1);
			elapsed_d = 8'h00;
			conv_d = '0;
			used_d = count_en(link.chan_en);
			chan_d = first_ch[1:0];
			state_d = first_ch[2] ? temp_sched_pkg::SEQ_CONV : temp_sched_pkg::SEQ_IDLE;
		end
	end

	// Elapsed starts saturated so the first sequence begins right after reset
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_q <= temp_sched_pkg::SEQ_IDLE;
			chan_q <= 2'h0;
			tick_q <= '0;
			conv_q <= '0;
			elapsed_q <= temp_sched_pkg::ELAPSED_MAX;
			used_q <= 8'h00;
		end else begin
			state_q <= state_d;
			chan_q <= chan_d;
			tick_q <= tick_d;
			conv_q <= conv_d;
			elapsed_q <= elapsed_d;
			used_q <= used_d;
		end
	end

	assign link.busy = (state_q == temp_sched_pkg::SEQ_CONV);
	assign link.active_chan = chan_q;

endmodule : sequence_engine

// *** src/temp_conversion_scheduler.sv ***
/*
 * Conversion scheduler top: two-wire serial target, the rate, run and
 * channel registers, and the sequence engine behind them.
 * Assumes scl_in/sda_in are already synchronous to ref_clk and the pad
 * resolves sda from sda_oe_n (low = pull low).
 */
// Operation
// - Rate register at 0x0b, resets to 0x07
// - Rate stretches idle only, conversion fixed
// - Code 0 is 16 s, halving per step
// - One-shot starts a pass on enabled channels
// - Code 6 capped by three or four channels
// - Code 7 capped beyond one channel
// - Channel setup bit 2 enables series correction
// - Answer serial target address 1001100
// - Local, remote 1..3 order, skip disabled
// - Halt bit stops after current sequence
// - Busy bit reads one while converting
// - Bits 3..6 include their channel
`timescale 1ns/1ps
module temp_conversion_scheduler #(
	parameter int TICK_CYCLES = temp_sched_pkg::TICK_CYCLES,
	parameter int CONV_CYCLES = temp_sched_pkg::CONV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic conv_busy,
	output logic [1:0] active_chan,
	output logic series_res_fix_en,
	output logic range_extended
);
	logic [1:0] rst_pipe_q;
	logic rst_sync_b;
	sched_link_if link ();

	// ==========================================================
	// Reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe_q <= 2'b00;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe_q[1];

	// ==========================================================
	// Serial bus condition detection
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	assign bus_start = scl_in && scl_q && sda_q && !sda_in;
	assign bus_stop = scl_in && scl_q && !sda_q && sda_in;

	// ==========================================================
	// Serial target state
	temp_sched_pkg::bus_state_type bus_q, bus_d;
	temp_sched_pkg::byte_kind_type kind_q, kind_d;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ptr_q, ptr_d;
	logic read_q, read_d;
	logic drive_q, drive_d;
	logic nack_q, nack_d;
	logic [7:0] byte_v;
	logic [7:0] rd_byte;
	logic wr_fire;

	// ==========================================================
	// Register state
	logic [7:0] rate_q, rate_d;
	logic [7:0] run_q, run_d;
	logic [7:0] setup_q, setup_d;

	assign byte_v = {shift_q[6:0], sda_in};
	// Data byte completes on the eighth rising clock
	assign wr_fire = (bus_q == temp_sched_pkg::BUS_RX) && scl_rise
		&& (bit_cnt_q == temp_sched_pkg::LAST_BIT) && (kind_q == temp_sched_pkg::KIND_DATA);

	// Read mux; unmapped pointers read as zero
	always_comb begin
		unique case (ptr_q)
			temp_sched_pkg::PTR_STATUS: rd_byte = {link.busy, 7'h00};
			temp_sched_pkg::PTR_RUN_CFG: rd_byte = run_q;
			temp_sched_pkg::PTR_CHANNEL_SETUP: rd_byte = setup_q;
			temp_sched_pkg::PTR_RATE: rd_byte = rate_q;
			default: rd_byte = temp_sched_pkg::READ_UNMAPPED;
		endcase
	end

	// Bus sequencing: address, pointer, then data bytes or read bytes
	always_comb begin
		bus_d = bus_q;
		kind_d = kind_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		read_d = read_q;
		drive_d = drive_q;
		nack_d = nack_q;
		unique case (bus_q)
			temp_sched_pkg::BUS_IDLE: begin
				drive_d = 1'b0;
			end
			temp_sched_pkg::BUS_RX: begin
				if (scl_rise) begin
					shift_d = byte_v;
					bit_cnt_d = bit_cnt_q + 3'h1;
					if (bit_cnt_q == temp_sched_pkg::LAST_BIT) begin
						bus_d = temp_sched_pkg::BUS_ACK_SETUP;
						unique case (kind_q)
							temp_sched_pkg::KIND_ADDR: begin
								read_d = byte_v[0];
								if (byte_v[7:1] != temp_sched_pkg::TARGET_ADDR) begin
									bus_d = temp_sched_pkg::BUS_IDLE;
								end
							end
							temp_sched_pkg::KIND_PTR: ptr_d = byte_v;
							temp_sched_pkg::KIND_DATA: ptr_d = ptr_q;
						endcase
					end
				end
			end
			temp_sched_pkg::BUS_ACK_SETUP: begin
				if (scl_fall) begin
					drive_d = 1'b1;
					bus_d = temp_sched_pkg::BUS_ACK;
				end
			end
			temp_sched_pkg::BUS_ACK: begin
				if (scl_fall) begin
					bit_cnt_d = 3'h0;
					if (read_q && kind_q == temp_sched_pkg::KIND_ADDR) begin
						shift_d = rd_byte;
						drive_d = !rd_byte[7];
						bus_d = temp_sched_pkg::BUS_TX;
					end else begin
						drive_d = 1'b0;
						bus_d = temp_sched_pkg::BUS_RX;
						kind_d = (kind_q == temp_sched_pkg::KIND_ADDR) ?
							temp_sched_pkg::KIND_PTR : temp_sched_pkg::KIND_DATA;
					end
				end
			end
			temp_sched_pkg::BUS_TX: begin
				if (scl_fall) begin
					if (bit_cnt_q == temp_sched_pkg::LAST_BIT) begin
						drive_d = 1'b0;
						bus_d = temp_sched_pkg::BUS_TX_ACK;
					end else begin
						shift_d = {shift_q[6:0], 1'b0};
						drive_d = !shift_q[6];
						bit_cnt_d = bit_cnt_q + 3'h1;
					end
				end
			end
			temp_sched_pkg::BUS_TX_ACK: begin
				if (scl_rise) begin
					nack_d = sda_in;
				end
				if (scl_fall) begin
					// Acked reads repeat the same pointer
					bit_cnt_d = 3'h0;
					if (!nack_q) begin
						shift_d = rd_byte;
						drive_d = !rd_byte[7];
						bus_d = temp_sched_pkg::BUS_TX;
					end else begin
						bus_d = temp_sched_pkg::BUS_IDLE;
					end
				end
			end
			default: bus_d = temp_sched_pkg::BUS_IDLE;
		endcase
		// Start and stop override any byte in flight; pointer survives a restart
		if (bus_start) begin
			bus_d = temp_sched_pkg::BUS_RX;
			kind_d = temp_sched_pkg::KIND_ADDR;
			bit_cnt_d = 3'h0;
			read_d = 1'b0;
			drive_d = 1'b0;
		end else if (bus_stop) begin
			bus_d = temp_sched_pkg::BUS_IDLE;
			drive_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			bus_q <= temp_sched_pkg::BUS_IDLE;
			kind_q <= temp_sched_pkg::KIND_ADDR;
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			read_q <= 1'b0;
			drive_q <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			kind_q <= kind_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			read_q <= read_d;
			drive_q <= drive_d;
			nack_q <= nack_d;
		end
	end

	// ==========================================================
	// Register writes; run and setup reserved bits are masked, so host writes of ones there are dropped; rate keeps all eight bits
	always_comb begin
		rate_d = rate_q;
		run_d = run_q;
		setup_d = setup_q;
		if (wr_fire) begin
			unique case (ptr_q)
				temp_sched_pkg::PTR_RATE: rate_d = byte_v;
				temp_sched_pkg::PTR_RUN_CFG: run_d = byte_v & temp_sched_pkg::RUN_CFG_WR_MASK;
				temp_sched_pkg::PTR_CHANNEL_SETUP:
					setup_d = byte_v & temp_sched_pkg::CHANNEL_SETUP_WR_MASK;
				default: rate_d = rate_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rate_q <= temp_sched_pkg::RATE_RESET;
			run_q <= temp_sched_pkg::RUN_CFG_RESET;
			setup_q <= temp_sched_pkg::CHANNEL_SETUP_RESET;
		end else begin
			rate_q <= rate_d;
			run_q <= run_d;
			setup_q <= setup_d;
		end
	end

	// ==========================================================
	// Engine hookup; codes above seven use only the low three bits
	assign link.rate_code = rate_q[temp_sched_pkg::RATE_CODE_W-1:0];
	assign link.chan_en = setup_q[temp_sched_pkg::LOCAL_EN_BIT+:temp_sched_pkg::NUM_CHAN];
	assign link.halt = run_q[temp_sched_pkg::HALT_BIT];
	assign link.one_shot = wr_fire && (ptr_q == temp_sched_pkg::PTR_ONE_SHOT);

	sequence_engine #(
		.TICK_CYCLES(TICK_CYCLES),
		.CONV_CYCLES(CONV_CYCLES)
	) u_engine (
		.ref_clk(ref_clk),
		.rst_sync_b(rst_sync_b),
		.link(link)
	);

	// ==========================================================
	// Outputs
	assign sda_out = 1'b0;
	assign sda_oe_n = !drive_q;
	assign conv_busy = link.busy;
	assign active_chan = link.active_chan;
	assign series_res_fix_en = setup_q[temp_sched_pkg::FIX_EN_BIT];
	assign range_extended = run_q[temp_sched_pkg::RANGE_BIT];

endmodule : temp_conversion_scheduler

// *** bench/temp_conversion_scheduler_sva.sv ***
/*
 * Port checker for the conversion scheduler: serial answers, busy runs, channel steps.
 * Assumes one clock and sees only the top ports; bound at the foot of this file.
 */
`timescale 1ns/1ps
module temp_conversion_scheduler_sva #(
	parameter int TICK_CYCLES = temp_sched_pkg::TICK_CYCLES,
	parameter int CONV_CYCLES = temp_sched_pkg::CONV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic conv_busy,
	input wire logic [1:0] active_chan,
	input wire logic series_res_fix_en,
	input wire logic range_extended
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Wide enough for four full conversions at the real conversion length
	localparam int RUN_W = $clog2(4 * CONV_CYCLES + 2);
	logic [RUN_W-1:0] run_q;
	logic [RUN_W-1:0] run_d;

	// ======
	// Busy run length; a gap between channels would split one pass in two
	always_comb begin
		run_d = conv_busy ? run_q + RUN_W'(1) : '0;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= '0;
		end else begin
			run_q <= run_d;
		end
	end

	// ======
	// Steps of an acknowledge and of a channel slot
	sequence ack_held;
		(!sda_oe_n)[*6];
	endsequence
	sequence chan_held;
		$stable(active_chan)[*8];
	endsequence

	// ======
	// Checks
	chk_drive_value: assert property (sda_out == 1'b0)
		else $error("sda data value is not zero");
	chk_reset_values: assert property ($rose(rst_b) |->
		series_res_fix_en && !range_extended && sda_oe_n && !conv_busy)
		else $error("outputs wrong at reset release");
	chk_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("sda drive changed while scl high");
	chk_ack_stands: assert property ($fell(sda_oe_n) |-> ack_held)
		else $error("sda pull released too early");
	chk_fix_en_write: assert property ($changed(series_res_fix_en) |-> $past(scl_in))
		else $error("correction enable changed outside a write");
	chk_busy_whole: assert property ($fell(conv_busy) |->
		(run_q % CONV_CYCLES == 0) && (run_q <= 4 * CONV_CYCLES))
		else $error("busy run not whole conversions");
	chk_chan_steady: assert property ($changed(active_chan) |=> chan_held)
		else $error("channel changed inside a slot");
	chk_chan_ascends: assert property (conv_busy && $past(conv_busy)
		&& $changed(active_chan) |-> active_chan > $past(active_chan))
		else $error("channel order not ascending");
endmodule : temp_conversion_scheduler_sva

bind temp_conversion_scheduler temp_conversion_scheduler_sva #(
	.TICK_CYCLES(TICK_CYCLES), .CONV_CYCLES(CONV_CYCLES)
) temp_conversion_scheduler_sva_inst (
	.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_busy(conv_busy),
	.active_chan(active_chan), .series_res_fix_en(series_res_fix_en),
	.range_extended(range_extended)
);

// *** bench/smbus_host_model.sv ***
/*
 * Host controller on the two-wire port: byte, write, read and address probe tasks.
 * Assumes the bench resolves sda with a pull-up and feeds the level back here.
 */
`timescale 1ns/1ps
module smbus_host_model #(
	parameter logic [6:0] ADDR = 7'h4c
) (
	input wire logic ref_clk,
	input wire logic sda_bus,
	output logic scl,
	output logic sda_drv
);
	// Idle bus: both lines released high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// ======
	// Bit level; four clocks per scl half leaves margin over the two-clock minimum
	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask : half
	task automatic start();
		@(negedge ref_clk);
		sda_drv = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_drv = 1'b0;
		half();
		scl = 1'b0;
	endtask : start
	task automatic stop();
		@(negedge ref_clk);
		sda_drv = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_drv = 1'b1;
		half();
	endtask : stop
	// Data moves only while scl is low
	task automatic bit_io(input logic b, output logic s);
		@(negedge ref_clk);
		sda_drv = b;
		half();
		scl = 1'b1;
		half();
		s = sda_bus;
		scl = 1'b0;
	endtask : bit_io

	// ======
	// Byte level, most significant bit first
	task automatic xfer(input logic [7:0] v, output logic ok);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], s);
		end
		bit_io(1'b1, s);
		ok = !s;
	endtask : xfer
	task automatic recv(output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, v[i]);
		end
		bit_io(1'b1, s);
	endtask : recv

	// ======
	// Transfers; callers keep reserved bits at zero
	task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, output logic ok);
		logic a0, a1, a2;
		start();
		xfer({ADDR, 1'b0}, a0);
		xfer(ptr, a1);
		xfer(dat, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : wr
	task automatic rd(input logic [7:0] ptr, output logic [7:0] dat, output logic ok);
		logic a0, a1, a2;
		start();
		xfer({ADDR, 1'b0}, a0);
		xfer(ptr, a1);
		start();
		xfer({ADDR, 1'b1}, a2);
		recv(dat);
		stop();
		ok = a0 & a1 & a2;
	endtask : rd
	task automatic probe(input logic [6:0] a, output logic ok);
		start();
		xfer({a, 1'b0}, ok);
		stop();
	endtask : probe
endmodule : smbus_host_model

// *** bench/temp_conversion_scheduler_tb_top.sv ***
/*
 * Bench for the conversion scheduler: register access, pass order, periods, halt.
 * Assumes the host model and checker compile alongside; short tick and conversion.
 */
`timescale 1ns/1ps
module temp_conversion_scheduler_tb_top;
	localparam int TICK = 100;
	localparam int CONV = 30;
	localparam int LIMIT = 60000;
	logic ref_clk;
	logic rst_b;
	logic scl;
	logic sda_drv;
	logic sda_bus;
	logic sda_out;
	logic sda_oe_n;
	logic conv_busy;
	logic [1:0] active_chan;
	logic series_res_fix_en;
	logic range_extended;
	logic ok;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [7:0] tcode [7] = '{8'h07, 8'h07, 8'h07, 8'h06, 8'h06, 8'h06, 8'h03};
	logic [7:0] tset [7] = '{8'h08, 8'h30, 8'h58, 8'h78, 8'h3c, 8'h30, 8'h08};
	int tticks [7] = '{1, 2, 3, 4, 3, 2, 16};
	logic [6:0] paddr [3] = '{7'h4c, 7'h4d, 7'h0c};
	logic pexp [3] = '{1'b1, 1'b0, 1'b0};

	// Open-drain line with pull-up: low if either side pulls
	assign sda_bus = sda_drv & (sda_oe_n | sda_out);

	temp_conversion_scheduler #(.TICK_CYCLES(TICK), .CONV_CYCLES(CONV))
	temp_conversion_scheduler_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_bus),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_busy(conv_busy),
		.active_chan(active_chan), .series_res_fix_en(series_res_fix_en),
		.range_extended(range_extended)
	);
	smbus_host_model smbus_host_model_inst (
		.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv)
	);

	// ======
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			complete_run();
		end
	end

	// ======
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic a;
		smbus_host_model_inst.wr(p, d, a);
		check(a, 1'b1);
	endtask : wr
	task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
		logic a;
		logic [7:0] d;
		smbus_host_model_inst.rd(p, d, a);
		check({a, d}, {1'b1, e});
	endtask : rd_chk
	// Bounded wait so a dead engine cannot stall the run
	task automatic wait_lvl(input logic v);
		int n = 0;
		while (conv_busy !== v && n < 20000) begin
			@(negedge ref_clk);
			n++;
		end
		// A level that never comes is a failure, not a silent pass
		if (conv_busy !== v) begin
			err_total++;
			complete_run();
		end
	endtask : wait_lvl
	task automatic quiet();
		logic seen = 1'b0;
		wait_lvl(1'b0);
		repeat (600) begin
			@(negedge ref_clk);
			seen |= (conv_busy !== 1'b0);
		end
		check(seen, 1'b0);
	endtask : quiet
	// One full pass: channel in each slot, busy to the last cycle, then start spacing
	task automatic meas(input logic [7:0] st, input int ticks);
		int t0;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		t0 = cyc;
		for (int k = 0; k < 4; k++) begin
			if (st[3 + k]) begin
				repeat (CONV / 2) @(negedge ref_clk);
				check(active_chan, k);
				repeat (CONV / 2 - 1) @(negedge ref_clk);
				check(conv_busy, 1'b1);
				@(negedge ref_clk);
			end
		end
		check(conv_busy, 1'b0);
		wait_lvl(1'b1);
		check(cyc - t0, ticks * TICK);
	endtask : meas
	task automatic complete_run();
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// ======
	// Main sequence
	initial begin
		rst_b = 1'b0;
		repeat (10) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (6) @(negedge ref_clk);
		rd_chk(8'h0b, 8'h07);
		rd_chk(8'h0a, 8'h3c);
		check(series_res_fix_en, 1'b1);
		for (int i = 0; i < 3; i++) begin
			smbus_host_model_inst.probe(paddr[i], ok);
			check(ok, pexp[i]);
		end
		wr(8'h0c, 8'h5a);
		rd_chk(8'h0c, 8'h00);
		// Rate codes against channel counts, including the capped cases
		for (int i = 0; i < 7; i++) begin
			wr(8'h0a, tset[i]);
			wr(8'h0b, tcode[i]);
			rd_chk(8'h0b, tcode[i]);
			check(series_res_fix_en, tset[i][2]);
			meas(tset[i], tticks[i]);
		end
		// One-shot in a long idle, then halt, one-shot while halted, resume
		wr(8'h0a, 8'h3c);
		wr(8'h0b, 8'h00);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wr(8'h0f, 8'h00);
		check(conv_busy, 1'b1);
		wr(8'h0b, 8'h07);
		wr(8'h09, 8'h40);
		rd_chk(8'h09, 8'h40);
		quiet();
		wr(8'h0f, 8'h00);
		check(conv_busy, 1'b1);
		quiet();
		rd_chk(8'h08, 8'h00);
		wr(8'h09, 8'h04);
		check(conv_busy, 1'b1);
		check(range_extended, 1'b1);
		complete_run();
	end
endmodule : temp_conversion_scheduler_tb_top
